// file: src/acss_top.sv
/*
 * clock source select and optical input supervision, wishbone slave.
 * assumes the optical receiver gives lock and format levels and its
 * recovered clock as pins, all asynchronous to ref_clk_in.
 */
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module acss_top
    import acss_pkg::*;
#(
    parameter longint GATE_CYCLES = GATE_CYC, // rate window in cycles
    parameter int     LINK_PER_FS = 256       // link clocks per sample
) (
    input  wire logic        ref_clk_in,          // 200 MHz clock
    input  wire logic        rst_in,              // sync reset, high
    input  wire logic        wb_cyc_in,           // wishbone cycle
    input  wire logic        wb_stb_in,           // wishbone strobe
    input  wire logic        wb_we_in,            // write enable
    input  wire logic [7:0]  wb_adr_in,           // byte address
    input  wire logic [31:0] wb_dat_in,           // write data
    input  wire logic [3:0]  wb_sel_in,           // byte lanes
    output logic [31:0]      wb_dat_out,          // read data
    output logic             wb_ack_out,          // acknowledge
    output logic             irq_out,             // level interrupt
    input  wire logic        opt_clk_in,          // recovered link clock
    input  wire logic        opt_lock_in,         // receiver lock
    input  wire logic        opt_fmt_mc_in,       // 1 multichannel frame
    input  wire logic        fw_prog_fail_in,     // programming failed
    input  wire logic        nv_backup_in,        // stored boot choice
    output logic             work_clk_out,        // working clock level
    output logic             tx_spdif_out,        // transmitter spdif
    output logic             tx_mc_connect_out,   // multichannel stream on
    output logic             tx_cs_pro_out,       // channel status pro
    output logic [1:0]       eq_src_out,          // record eq source
    output logic             two_wire_sample_multiplexing_out, // mux on
    output logic [3:0]       mc_chan_out,         // multichannel count
    output logic             boot_backup_req_out, // boot backup next
    output logic             boot_image_backup_out // running backup
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic       lclk_d;
    // first stage read only by the second
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sync1  <= 3'h0;
            sync2  <= 3'h0;
            lclk_d <= 1'b0;
        end else begin
            sync1  <= {opt_fmt_mc_in, opt_lock_in, opt_clk_in};
            sync2  <= sync1;
            lclk_d <= sync2[0];
        end
    end
    logic lclk;
    logic lock_s;
    logic fmt_mc;
    logic lrise;
    assign lclk   = sync2[0];
    assign lock_s = sync2[1];
    assign fmt_mc = sync2[2];
    assign lrise  = lclk & ~lclk_d;

    // ----------------------------------------------------------------
    // input monitor: activity and coarse rate
    // ----------------------------------------------------------------
    function automatic logic [23:0] thr(input longint hz);
        thr = 24'(hz * LINK_PER_FS * GATE_CYCLES / REF_HZ);
    endfunction
    localparam logic [23:0] GATE_LAST = 24'(GATE_CYCLES - 1);
    localparam logic [9:0]  TMO_LAST  = 10'(ACT_TMO_CYC);

    logic [23:0] gate_cnt, next_gate_cnt;
    logic [23:0] edge_cnt, next_edge_cnt;
    logic [9:0]  idle_cnt, next_idle_cnt;
    logic [2:0]  rate, next_rate;
    logic        valid;

    // runs whatever clock is used
    // the monitor never stops, so a returning signal is seen at once
    always_comb begin
        next_gate_cnt = gate_cnt + 24'h1;
        next_edge_cnt = edge_cnt + {23'h0, lrise};
        next_idle_cnt = lrise ? 10'h0 : idle_cnt;
        next_rate     = rate;
        if (!lrise && idle_cnt != TMO_LAST) begin
            next_idle_cnt = idle_cnt + 10'h1;
        end
        if (gate_cnt == GATE_LAST) begin
            next_gate_cnt = 24'h0;
            next_edge_cnt = 24'h0;
            if      (edge_cnt < thr(MID_NONE))  next_rate = RATE_NONE;
            else if (edge_cnt < thr(MID_32_44)) next_rate = RATE_32K;
            else if (edge_cnt < thr(MID_44_48)) next_rate = RATE_44K1;
            else if (edge_cnt < thr(MID_48_64)) next_rate = RATE_48K;
            else if (edge_cnt < thr(MID_64_88)) next_rate = RATE_64K;
            else if (edge_cnt < thr(MID_88_96)) next_rate = RATE_88K2;
            else if (edge_cnt < thr(MID_96_HI)) next_rate = RATE_96K;
            else                                next_rate = RATE_HIGH;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            gate_cnt <= 24'h0;
            edge_cnt <= 24'h0;
            idle_cnt <= 10'h0;
            rate     <= RATE_NONE;
        end else begin
            gate_cnt <= next_gate_cnt;
            edge_cnt <= next_edge_cnt;
            idle_cnt <= next_idle_cnt;
            rate     <= next_rate;
        end
    end
    // valid needs receiver lock and a clock that still toggles
    assign valid = lock_s && idle_cnt != TMO_LAST;

    // ----------------------------------------------------------------
    // clock source state machine
    // ----------------------------------------------------------------
    typedef enum logic {ST_INT, ST_EXT} acss_src_e;
    acss_src_e  st, next_st;
    acss_ctrl_s ctrl;

    always_comb begin
        next_st = st;
        unique case (st)
            ST_INT: begin
                if (ctrl.src_opt && valid) begin
                    next_st = ST_EXT;
                end
            end
            ST_EXT: begin
                if (!ctrl.src_opt || !valid) begin
                    next_st = ST_INT;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            st <= ST_INT;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // working clock
    // ----------------------------------------------------------------
    logic [2:0] div_cnt, next_div_cnt;
    logic       xtal, next_xtal;
    // crystal stand-in divided from the reference clock
    always_comb begin
        next_div_cnt = div_cnt + 3'h1;
        next_xtal    = xtal;
        if (div_cnt == 3'(INT_HALF - 1)) begin
            next_div_cnt = 3'h0;
            next_xtal    = ~xtal;
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            div_cnt <= 3'h0;
            xtal    <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            xtal    <= next_xtal;
        end
    end

    acss_clk_switch u_switch (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .sel_in     (st == ST_EXT),
        .a_in       (xtal),
        .b_in       (lclk),
        .clk_out    (work_clk_out),
        .cur_out    ()
    );

    // ----------------------------------------------------------------
    // status, outputs and events
    // ----------------------------------------------------------------
    acss_instat_s instat, next_instat;
    logic         fw_fail, next_fw_fail;
    logic         boot_taken;
    logic         valid_d;
    logic [IRQ_W-1:0] ev;

    always_comb begin
        next_fw_fail = fw_fail | fw_prog_fail_in;
        next_instat.state = !valid ? IN_NOLOCK :
                            (st == ST_EXT) ? IN_SYNC : IN_LOCK;
        next_instat.refc  = (st == ST_INT) ? REF_INT :
                            fmt_mc ? REF_MC : REF_SPDIF;
        next_instat.rate        = rate;
        next_instat.boot_backup = instat.boot_backup;
        next_instat.fw_fail     = next_fw_fail;
        ev = '0;
        ev[IRQ_LOCK_UP]  = valid & ~valid_d;
        ev[IRQ_LOCK_DN]  = ~valid & valid_d;
        ev[IRQ_SRC_CHG]  = next_st != st;
        ev[IRQ_RATE_CHG] = next_rate != rate;
        ev[IRQ_FW_FAIL]  = fw_prog_fail_in;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            instat     <= '0;
            fw_fail    <= 1'b0;
            valid_d    <= 1'b0;
            boot_taken <= 1'b0;
        end else begin
            instat  <= next_instat;
            fw_fail <= next_fw_fail;
            valid_d <= valid;
            if (!boot_taken) begin
                instat.boot_backup <= nv_backup_in;
                boot_taken         <= 1'b1;
            end
        end
    end

    assign boot_backup_req_out   = fw_fail;
    assign boot_image_backup_out = instat.boot_backup;

    // configuration outputs follow the control word one cycle later; channel status pro held low
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            tx_spdif_out      <= 1'b0;
            tx_mc_connect_out <= 1'b1;
            tx_cs_pro_out     <= 1'b0;
            eq_src_out        <= EQ_OFF;
            two_wire_sample_multiplexing_out <= 1'b0;
            mc_chan_out       <= CHAN_FULL;
        end else begin
            tx_spdif_out      <= ctrl.tx_spdif;
            tx_mc_connect_out <= ~ctrl.tx_spdif;
            tx_cs_pro_out     <= 1'b0;
            eq_src_out <= !ctrl.eq_rec ? EQ_OFF :
                          ctrl.loopback ? EQ_OUTPUT : EQ_INPUT;
            if (ctrl.rate == RATE_88K2 || ctrl.rate == RATE_96K) begin
                two_wire_sample_multiplexing_out <= 1'b1;
                mc_chan_out <= CHAN_MUX;
            end else begin
                two_wire_sample_multiplexing_out <= 1'b0;
                mc_chan_out <= CHAN_FULL;
            end
        end
    end

    // ----------------------------------------------------------------
    // wishbone slave and interrupt registers
    // ----------------------------------------------------------------
    logic             take, wr, rd;
    logic             next_ack;
    logic [31:0]      next_dat;
    acss_ctrl_s       next_ctrl;
    logic [IRQ_W-1:0] irq_stat, next_irq_stat;
    logic [IRQ_W-1:0] irq_mask, next_irq_mask;

    // the request is acted on at the edge where ack is seen high
    assign take = wb_cyc_in & wb_stb_in & wb_ack_out;
    assign wr   = take & wb_we_in & wb_sel_in[0];
    assign rd   = take & ~wb_we_in;

    always_comb begin
        next_ack      = wb_cyc_in & wb_stb_in & ~wb_ack_out;
        next_ctrl     = ctrl;
        next_irq_mask = irq_mask;
        next_dat      = 32'h0;
        if (wr && wb_adr_in == REG_CTRL) begin
            next_ctrl = wb_dat_in[CTRL_W-1:0];
        end
        if (wr && wb_adr_in == REG_IRQ_MASK) begin
            next_irq_mask = wb_dat_in[IRQ_W-1:0];
        end
        // read-clear, but a new event in the same cycle survives
        next_irq_stat = ((rd && wb_adr_in == REG_IRQ_STAT) ? '0 : irq_stat) | ev;
        if (next_ack && !wb_we_in) begin
            unique case (wb_adr_in)
                REG_CTRL:     next_dat = {25'h0, ctrl};
                REG_INSTAT:   next_dat = {23'h0, instat};
                // include this cycle's events, or the clear at the ack edge would drop them unseen
                REG_IRQ_STAT: next_dat = {27'h0, irq_stat | ev};
                REG_IRQ_MASK: next_dat = {27'h0, irq_mask};
                default:      next_dat = 32'h0; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0;
            ctrl       <= '0;
            irq_stat   <= '0;
            irq_mask   <= '0;
            irq_out    <= 1'b0;
        end else begin
            wb_ack_out <= next_ack;
            wb_dat_out <= next_dat;
            ctrl       <= next_ctrl;
            irq_stat   <= next_irq_stat;
            irq_mask   <= next_irq_mask;
            irq_out    <= |(next_irq_stat & next_irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    master_forces_int_a: assert property (!ctrl.src_opt |=> st == ST_INT)
        else $error("master mode left recovered clock in use");
    lost_lock_fallback_a: assert property (st == ST_EXT && !valid |=> st == ST_INT)
        else $error("no fallback to crystal on lost lock");
    monitor_runs_a: assert property (st == ST_INT && lrise |=> idle_cnt == 10'h0)
        else $error("input monitor stopped while on crystal");
    valid_moves_ext_a: assert property (st == ST_INT && ctrl.src_opt && valid |=> st == ST_EXT)
        else $error("valid input not taken as reference");
    internal_ref_shown_a: assert property (st == ST_INT |=> instat.refc == REF_INT)
        else $error("reference report wrong while on crystal");
    no_lock_shown_a: assert property (!valid |=> instat.state == IN_NOLOCK)
        else $error("input state not no lock");
    tx_exclusive_a: assert property (tx_mc_connect_out != tx_spdif_out)
        else $error("transmitter formats not exclusive");
    consumer_status_a: assert property (##1 !tx_cs_pro_out)
        else $error("professional channel status sent");
    write_immediate_a: assert property (wr && wb_adr_in == REG_CTRL |=> ctrl == $past(wb_dat_in[CTRL_W-1:0]))
        else $error("control write did not take effect");
    loopback_eq_a: assert property (ctrl.eq_rec && ctrl.loopback |=> eq_src_out == EQ_OUTPUT)
        else $error("loopback eq source wrong");
    fail_requests_backup_a: assert property (fw_prog_fail_in |=> boot_backup_req_out [*3])
        else $error("programming failure not held");
    double_speed_mux_a: assert property (ctrl.rate == RATE_96K |=> two_wire_sample_multiplexing_out
                                         && mc_chan_out == CHAN_MUX)
        else $error("double speed channel count wrong");
    no_runt_high_a: assert property ($rose(work_clk_out) |=> work_clk_out)
        else $error("runt high pulse on working clock");

    ext_taken_c: cover property (st == ST_INT ##1 st == ST_EXT);
    fallback_c:  cover property (st == ST_EXT && ctrl.src_opt ##1 st == ST_INT);
    rate_48k_c:  cover property (rate == RATE_48K);
    irq_c:       cover property ($rose(irq_out));
endmodule : acss_top
`default_nettype wire

// file: src/acss_pkg.sv
/*
 * constants, codes and carriers for the audio clock source select block.
 * assumes a 200 MHz reference clock and a classic wishbone register bus.
 */
// Behaviour
// - select internal crystal or recovered optical clock
// - slave without lock falls back to crystal
// - optical input watched continuously in optical mode
// - valid input moves to recovered clock; report reference
// - report no lock, lock or sync
// - coarse input rate as nearest standard rate
// - optical out multichannel or spdif, exclusive
// - spdif channel status always consumer
// - receiver format detected without configuration
// - register writes take effect immediately
// - record eq from inputs, or output when loopback
// - failed programming boots backup image next power-up
// - 88.2/96 kHz: two-wire multiplexing, 4 channels
package acss_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int unsigned ADR_W        = 8;
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_INSTAT   = 8'h04;
    localparam logic [7:0]  REG_IRQ_STAT = 8'h08;
    localparam logic [7:0]  REG_IRQ_MASK = 8'h0c;

    // control word, low byte of REG_CTRL
    typedef struct packed {
        logic [2:0] rate;      // configured sample rate code
        logic       loopback;  // output channel loopback active
        logic       eq_rec;    // eq in record path
        logic       tx_spdif;  // optical out sends spdif
        logic       src_opt;   // clock source optical (slave)
    } acss_ctrl_s;
    localparam int unsigned CTRL_W = 7;

    // input status word, REG_INSTAT
    typedef struct packed {
        logic       fw_fail;     // programming failure seen
        logic       boot_backup; // running from backup image
        logic [2:0] rate;        // measured rate code
        logic [1:0] refc;        // reference in use
        logic [1:0] state;       // no lock / lock / sync
    } acss_instat_s;
    localparam int unsigned INSTAT_W = 9;

    // rate codes
    localparam logic [2:0] RATE_NONE = 3'h0;
    localparam logic [2:0] RATE_32K  = 3'h1;
    localparam logic [2:0] RATE_44K1 = 3'h2;
    localparam logic [2:0] RATE_48K  = 3'h3;
    localparam logic [2:0] RATE_64K  = 3'h4;
    localparam logic [2:0] RATE_88K2 = 3'h5;
    localparam logic [2:0] RATE_96K  = 3'h6;
    localparam logic [2:0] RATE_HIGH = 3'h7;

    // input state, reference and eq codes
    localparam logic [1:0] IN_NOLOCK = 2'h0;
    localparam logic [1:0] IN_LOCK   = 2'h1;
    localparam logic [1:0] IN_SYNC   = 2'h2;
    localparam logic [1:0] REF_INT   = 2'h0;
    localparam logic [1:0] REF_MC    = 2'h1;
    localparam logic [1:0] REF_SPDIF = 2'h2;
    localparam logic [1:0] EQ_OFF    = 2'h0;
    localparam logic [1:0] EQ_INPUT  = 2'h1;
    localparam logic [1:0] EQ_OUTPUT = 2'h2;

    // interrupt bits
    localparam int unsigned IRQ_W        = 5;
    localparam int unsigned IRQ_LOCK_UP  = 0;
    localparam int unsigned IRQ_LOCK_DN  = 1;
    localparam int unsigned IRQ_SRC_CHG  = 2;
    localparam int unsigned IRQ_RATE_CHG = 3;
    localparam int unsigned IRQ_FW_FAIL  = 4;

    // multichannel port channel counts
    localparam logic [3:0] CHAN_FULL = 4'h8;
    localparam logic [3:0] CHAN_MUX  = 4'h4;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam longint REF_HZ      = 200_000_000;
    localparam longint GATE_US     = 1000;   // rate measuring window
    localparam longint GATE_CYC    = GATE_US * REF_HZ / 1_000_000;
    localparam longint ACT_TMO_NS  = 1000;   // link edge timeout
    localparam int unsigned ACT_TMO_CYC = int'(ACT_TMO_NS * REF_HZ / 1_000_000_000);
    localparam int unsigned INT_HALF = 4;    // crystal stand-in half period
    // decision points between standard rates, in Hz
    localparam longint MID_NONE  = 20_000;
    localparam longint MID_32_44 = 38_000;
    localparam longint MID_44_48 = 46_000;
    localparam longint MID_48_64 = 56_000;
    localparam longint MID_64_88 = 76_000;
    localparam longint MID_88_96 = 92_000;
    localparam longint MID_96_HI = 144_000;
endpackage : acss_pkg

// file: src/acss_clk_switch.sv
/*
 * glitch-free selection between two clock levels sampled on ref_clk_in.
 * assumes both sources stay high for at least two reference cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module acss_clk_switch
    import acss_pkg::*;
(
    input  wire logic ref_clk_in, // reference clock
    input  wire logic rst_in,     // sync reset, high
    input  wire logic sel_in,     // 1 selects source b
    input  wire logic a_in,       // source a level
    input  wire logic b_in,       // source b level
    output logic      clk_out,    // switched clock level
    output logic      cur_out     // source now passed
);
    logic cur;
    logic next_cur;
    logic next_clk;

    // ----------------------------------------------------------------
    // switch point
    // ----------------------------------------------------------------
    // only hand over low
    // changing while output and new source are both low keeps every
    // high phase whole; a low phase may stretch, never shorten a high
    always_comb begin
        next_cur = cur;
        if (sel_in != cur && !clk_out && !(sel_in ? b_in : a_in)) begin
            next_cur = sel_in;
        end
        next_clk = next_cur ? b_in : a_in;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cur     <= 1'b0;
            clk_out <= 1'b0;
        end else begin
            cur     <= next_cur;
            clk_out <= next_clk;
        end
    end

    assign cur_out = cur;
endmodule : acss_clk_switch
`default_nettype wire

// file: testbench/acss_link_model.sv
/*
 * far-side optical source: recovered link clock, lock and format pins.
 * assumes the bench drives en_in and mc_in right after ref_clk_in edges.
 */
`timescale 1ns/1ps
`default_nettype none
module acss_link_model (
    input  wire logic en_in,      // link carries a frame stream
    input  wire logic mc_in,      // 1 multichannel, 0 spdif
    output logic      clk_out,    // link clock, 48 ns period
    output logic      lock_out,   // receiver lock level
    output logic      fmt_mc_out  // receiver format level
);
    // ----------------------------------------------------------------
    // link clock, still outside frames so no stale edges leak in
    // ----------------------------------------------------------------
    initial clk_out = 1'b0;
    always begin
        #24;
        clk_out = en_in ? ~clk_out : 1'b0;
    end
    // lock and format; format is meaningless while unlocked, so invert it
    assign lock_out   = en_in;
    assign fmt_mc_out = en_in ? mc_in : ~mc_in;
endmodule : acss_link_model
`default_nettype wire

// file: testbench/tb.sv
/*
 * self-checking bench for acss_top: wishbone tasks and a control model.
 * assumes acss_link_model stands in for the optical receiver.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import acss_pkg::*;
    localparam int   HZ = 1000000000 / (48 * 256);
    localparam logic [2:0] XR = HZ < MID_NONE ? 3'h0 : HZ < MID_32_44 ? 3'h1 : HZ < MID_44_48 ? 3'h2 :
        HZ < MID_48_64 ? 3'h3 : HZ < MID_64_88 ? 3'h4 : HZ < MID_88_96 ? 3'h5 : HZ < MID_96_HI ? 3'h6 : 3'h7;
    logic        clk, rst, cyc, stb, we, fw_fail, nv, link_en, link_mc;
    logic [7:0]  adr;
    logic [31:0] dat, rd;
    logic [3:0]  sel;
    wire logic [31:0] wb_q;
    wire logic        ack, irq, oclk, olock, omc, wclk, spd, mcc, pro, mux, breq, bimg;
    wire logic [1:0]  eq;
    wire logic [3:0]  chan;
    int          n_mismatch, compares, cyc_cnt, seed, v, i, mctrl;

    acss_top #(.GATE_CYCLES(2000)) acss_top_i (.ref_clk_in(clk), .rst_in(rst), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(dat), .wb_sel_in(sel),
        .wb_dat_out(wb_q), .wb_ack_out(ack), .irq_out(irq), .opt_clk_in(oclk), .opt_lock_in(olock),
        .opt_fmt_mc_in(omc), .fw_prog_fail_in(fw_fail), .nv_backup_in(nv), .work_clk_out(wclk),
        .tx_spdif_out(spd), .tx_mc_connect_out(mcc), .tx_cs_pro_out(pro), .eq_src_out(eq),
        .two_wire_sample_multiplexing_out(mux), .mc_chan_out(chan), .boot_backup_req_out(breq),
        .boot_image_backup_out(bimg));
    acss_link_model acss_link_model_i (.en_in(link_en), .mc_in(link_mc), .clk_out(oclk),
        .lock_out(olock), .fmt_mc_out(omc));

    // ----------------------------------------------------------------
    // clock, timeout and shared tasks
    // ----------------------------------------------------------------
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic summarize();
        $display("counts: compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // classic cycle: hold until ack is sampled, then release for a cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
        do @(posedge clk); while (ack !== 1'b1);
        rd = wb_q;
        cyc <= 1'b0; stb <= 1'b0;
    endtask : wb
    task automatic instat(input logic [1:0] st, input logic [1:0] rf, input logic [2:0] rt);
        wb(1'b0, REG_INSTAT, 32'h0);
        chk(rd, {23'h0, 1'b0, 1'b1, rt, rf, st});
    endtask : instat
    // working clock rises over 2400 ns, one either way for phase
    task automatic clk_rate(input int per_ns);
        int   n;
        logic p;
        n = 0;
        p = wclk;
        repeat (480) begin
            @(posedge clk);
            n += int'(wclk & ~p);
            p = wclk;
        end
        chk(n >= 2400 / per_ns - 1 && n <= 2400 / per_ns + 1, 1'b1);
    endtask : clk_rate

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 0; rst = 1; cyc = 0; stb = 0; we = 0; adr = 0; dat = 0; sel = 0; fw_fail = 0;
        nv = 1; link_en = 0; link_mc = 1; seed = 32'h68142702; n_mismatch = 0; compares = 0; cyc_cnt = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk({spd, mcc, pro, eq, mux, chan, irq, breq, bimg}, {3'b010, EQ_OFF, 1'b0, CHAN_FULL, 3'b001});
        $display("test reset done");
        // every rate code, random eq, loopback and transmitter bits
        for (i = 0; i < 16; i++) begin
            v = $random(seed);
            mctrl = {i[2:0], v[3:1], 1'b0};
            wb(1'b1, REG_CTRL, mctrl);
            repeat (2) @(posedge clk);
            chk({spd, mcc, pro, eq, mux, chan}, {mctrl[1], !mctrl[1], 1'b0, mctrl[2] ? (mctrl[3] ? EQ_OUTPUT :
                EQ_INPUT) : EQ_OFF, i[2:0] inside {3'h5, 3'h6}, i[2:0] inside {3'h5, 3'h6} ? CHAN_MUX : CHAN_FULL});
            wb(1'b0, REG_CTRL, 32'h0);
            chk(rd, mctrl);
        end
        wb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        $display("test control done");
        // link comes up in slave mode with lock-up interrupt unmasked, interrupt raised, then cleared by a status read
        wb(1'b0, REG_IRQ_STAT, 32'h0);
        wb(1'b1, REG_IRQ_MASK, 32'h1 << IRQ_LOCK_UP);
        wb(1'b1, REG_CTRL, 32'h1);
        link_en <= 1'b1;
        repeat (4500) @(posedge clk);
        chk(irq, 1'b1);
        instat(IN_SYNC, REF_MC, XR);
        clk_rate(48);
        wb(1'b0, REG_IRQ_STAT, 32'h0);
        chk(rd, 32'h0d);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        link_mc <= 1'b0;
        repeat (50) @(posedge clk);
        instat(IN_SYNC, REF_SPDIF, XR);
        wb(1'b1, REG_CTRL, 32'h0);
        repeat (50) @(posedge clk);
        instat(IN_LOCK, REF_INT, XR);
        clk_rate(2 * INT_HALF * 5);
        wb(1'b1, REG_CTRL, 32'h1);
        repeat (50) @(posedge clk);
        instat(IN_SYNC, REF_SPDIF, XR);
        link_en <= 1'b0;
        repeat (4500) @(posedge clk);
        instat(IN_NOLOCK, REF_INT, RATE_NONE);
        $display("test link done");
        fw_fail <= 1'b1;
        @(posedge clk);
        fw_fail <= 1'b0;
        repeat (3) @(posedge clk);
        chk({breq, bimg}, 2'b11);
        wb(1'b0, REG_INSTAT, 32'h0);
        chk(rd[8], 1'b1);
        wb(1'b0, REG_IRQ_STAT, 32'h0);
        chk(rd[IRQ_FW_FAIL], 1'b1);
        $display("test firmware done");
        summarize();
    end
endmodule : tb
`default_nettype wire
